/* File: rtl/orc_core.sv */
`timescale 1ns/1ps
module orc_core (
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    // code fetch: 16 bits per state
    input  wire logic [15:0]          code_in,
    input  wire logic                 code_vld_in,
    output logic [23:0]               code_addr_out,
    // decoded instruction supplied by the front decoder
    input  wire orc_pkg::orc_instr_t  dec_in,
    // byte-wide data bus
    output logic [23:0]               data_addr_out,
    output logic                      data_rd_out,
    output logic                      data_wr_out,
    output logic [7:0]                data_wdata_out,
    input  wire logic [7:0]           data_rdata_in,
    // register banks
    input  wire logic [1:0]           bank_sel_in,
    // interrupts
    input  wire logic [61:0]          irq_req_in,
    input  wire logic [61:0]          irq_en_in,
    input  wire logic [123:0]         irq_prio_in,
    input  wire logic                 nmi_in,
    input  wire logic                 brk_in,
    output logic                      irq_take_out,
    output logic [5:0]                irq_id_out,
    // results
    output logic                      state_out,
    output logic [15:0]               fetch_word_out,
    output logic [31:0]               result_out,
    output logic [23:0]               ea_out,
    output logic                      wb_vld_out,
    output logic                      width_err_out
);
    // ------------------------------------------------------------------
    // state timing
    // ------------------------------------------------------------------
    logic       phase_r;
    logic       adv;
    assign adv       = phase_r;
    assign state_out = phase_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) phase_r <= 1'b0;
        else           phase_r <= ~phase_r;
    end

    // ------------------------------------------------------------------
    // register storage: banks 0..31 plus 32 file bytes
    // ------------------------------------------------------------------
    logic [7:0] rf_r [orc_pkg::RF_BYTES];

    // physical byte index; 0..7 follow the chosen bank
    function automatic logic [5:0] phys(input logic [5:0] r,
                                        input logic [1:0] b);
        if (r < orc_pkg::BANK_REGS) phys = {1'b0, b, r[2:0]};
        else                        phys = r + orc_pkg::FILE_OFS;
        // 56..63 keep bytes of their own, so all ten dwords stay distinct
        if (r >= orc_pkg::DW_LO) phys = r;
    endfunction : phys

    // legal register number for a width
    function automatic logic legal(input logic [5:0] r,
                                   input orc_pkg::orc_width_t w);
        case (w)
            orc_pkg::W_BYTE:  legal = r <= orc_pkg::BYTE_MAX;
            orc_pkg::W_WORD:  legal = !r[0] &&
                                      r <= orc_pkg::WORD_MAX;
            orc_pkg::W_DWORD: legal = r[1:0] == 2'h0 &&
                (r <= orc_pkg::WORD_MAX || r >= orc_pkg::DW_LO);
            default:          legal = 1'b1;
        endcase
    endfunction : legal

    function automatic logic [31:0] rd_reg(input logic [5:0] r,
                                           input logic [1:0] b,
                                           input orc_pkg::orc_width_t w);
        logic [31:0] v;
        v = 32'h0;
        v[7:0] = rf_r[phys(r, b)];
        if (w != orc_pkg::W_BYTE) v[15:8]  = rf_r[phys(r + 6'h01, b)];
        if (w == orc_pkg::W_DWORD) begin
            v[23:16] = rf_r[phys(r + 6'h02, b)];
            v[31:24] = rf_r[phys(r + 6'h03, b)];
        end
        rd_reg = v;
    endfunction : rd_reg

    // ------------------------------------------------------------------
    // stage 1: fetch and decode
    // ------------------------------------------------------------------
    logic [23:0]         pc_r;
    orc_pkg::orc_instr_t s1_r, s2_r;
    logic [15:0]         fw_r;

    assign code_addr_out  = pc_r;
    assign fetch_word_out = fw_r;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pc_r <= 24'h0;
            fw_r <= 16'h0;
            s1_r <= '0;
        end else if (adv) begin
            fw_r <= code_in;
            if (code_vld_in) pc_r <= pc_r + orc_pkg::FETCH_STEP;
            s1_r <= dec_in;
        end
    end

    // ------------------------------------------------------------------
    // stage 2: address generation and operand fetch
    // ------------------------------------------------------------------
    logic [31:0] opnd_r;
    logic [23:0] ea_r;
    logic [31:0] rs_val;
    logic [23:0] ea_nxt;
    logic [31:0] opnd_nxt;

    // a process, not an assign: a file write must re-evaluate the read
    always_comb rs_val = rd_reg(s1_r.rs, bank_sel_in, s1_r.width);

    always_comb begin
        ea_nxt   = 24'h0;
        opnd_nxt = 32'h0;
        case (s1_r.mode)
            orc_pkg::M_REG:  opnd_nxt = rs_val;
            orc_pkg::M_IMM:  opnd_nxt = {8'h0, s1_r.imm};
            orc_pkg::M_DIR:  ea_nxt = s1_r.imm;
            orc_pkg::M_IND:  ea_nxt = rs_val[23:0];
            orc_pkg::M_DISP: ea_nxt = rs_val[23:0] +
                             {{8{s1_r.imm[15]}}, s1_r.imm[15:0]};
            orc_pkg::M_REL:  ea_nxt = s1_r.next_pc +
                             {{16{s1_r.imm[7]}}, s1_r.imm[7:0]};
            orc_pkg::M_BIT:  ea_nxt = s1_r.imm;
            default:         ea_nxt = 24'h0;
        endcase
    end

    // reads own the second clock of a state, bit writes the first, so the
    // byte bus never carries both and a write goes to its own address
    assign data_addr_out = phase_r ? ea_nxt : ea_r;
    assign data_rd_out   = s1_r.valid && adv && s1_r.kind != orc_pkg::OP_FLOW
        && (s1_r.mode == orc_pkg::M_DIR || s1_r.mode == orc_pkg::M_IND ||
            s1_r.mode == orc_pkg::M_DISP || s1_r.mode == orc_pkg::M_BIT);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s2_r   <= '0;
            opnd_r <= 32'h0;
            ea_r   <= 24'h0;
        end else if (adv) begin
            s2_r <= s1_r;
            ea_r <= ea_nxt;
            opnd_r <= data_rd_out ? {24'h0, data_rdata_in}
                                  : opnd_nxt;
        end
    end

    // ------------------------------------------------------------------
    // stage 3: execute and write back
    // ------------------------------------------------------------------
    logic [31:0] res_r;
    logic        wb_r, err_r;
    logic        ok3;
    logic [5:0]  p0;

    assign ok3 = legal(s2_r.rd, s2_r.width);
    assign p0  = phys(s2_r.rd, bank_sel_in);
    assign result_out    = res_r;
    assign ea_out        = ea_r;
    assign wb_vld_out    = wb_r;
    assign width_err_out = err_r;
    assign data_wr_out   = !adv && s2_r.valid &&
                           s2_r.kind == orc_pkg::OP_BIT;
    assign data_wdata_out = opnd_r[7:0] ^ (8'h01 << ea_r[2:0]);

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            res_r <= 32'h0;
            wb_r  <= 1'b0;
            err_r <= 1'b0;
        end else if (adv) begin
            res_r <= opnd_r;
            wb_r  <= s2_r.valid && s2_r.kind == orc_pkg::OP_DATA && ok3;
            err_r <= s2_r.valid && s2_r.kind == orc_pkg::OP_DATA && !ok3;
        end
    end

    // only data ops with a legal destination touch the file
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < orc_pkg::RF_BYTES; i++) rf_r[i] <= 8'h00;
        end else if (adv && s2_r.valid && s2_r.kind == orc_pkg::OP_DATA
                     && ok3) begin
            rf_r[p0] <= opnd_r[7:0];
            if (s2_r.width != orc_pkg::W_BYTE)
                rf_r[phys(s2_r.rd + 6'h01, bank_sel_in)] <= opnd_r[15:8];
            if (s2_r.width == orc_pkg::W_DWORD) begin
                rf_r[phys(s2_r.rd + 6'h02, bank_sel_in)] <= opnd_r[23:16];
                rf_r[phys(s2_r.rd + 6'h03, bank_sel_in)] <= opnd_r[31:24];
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt arbitration
    // ------------------------------------------------------------------
    orc_irq_arb u_arb (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .irq_req_in  (irq_req_in),
        .irq_en_in   (irq_en_in),
        .irq_prio_in (irq_prio_in),
        .nmi_in      (nmi_in),
        .brk_in      (brk_in),
        .take_out    (irq_take_out),
        .id_r_out    (irq_id_out)
    );

    chk_state_two: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) phase_r |=> !phase_r ##1 phase_r)
        else $error("state not two clocks");
    chk_byte_reject: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) adv && s2_r.valid &&
        s2_r.kind == orc_pkg::OP_DATA && s2_r.width == orc_pkg::W_BYTE &&
        s2_r.rd > orc_pkg::BYTE_MAX |=> err_r && !wb_r)
        else $error("byte access above 15 accepted");
    sequence s_to_stage2;
        !adv ##2 s2_r.valid;
    endsequence
    chk_pipe_pass: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) adv && dec_in.valid |=> s_to_stage2)
        else $error("instruction did not reach stage two");
    chk_pc_step: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) adv && code_vld_in |=>
        pc_r == $past(pc_r) + orc_pkg::FETCH_STEP)
        else $error("fetch did not take two bytes");
    chk_dword_only: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) adv && s2_r.valid &&
        s2_r.kind == orc_pkg::OP_DATA && s2_r.width != orc_pkg::W_DWORD &&
        s2_r.rd >= orc_pkg::DW_LO |=> err_r && !wb_r)
        else $error("narrow access to a dword-only register accepted");
    chk_ctrl_no_wb: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) adv && s2_r.valid &&
        s2_r.kind != orc_pkg::OP_DATA |=> !wb_r && !err_r)
        else $error("non-data op wrote the register file");
    chk_bit_write: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) adv && s1_r.valid &&
        s1_r.kind == orc_pkg::OP_BIT |=>
        data_wr_out && data_addr_out == $past(ea_nxt))
        else $error("bit op did not write back its own byte");
endmodule : orc_core

/* File: rtl/orc_pkg.sv */
// Behaviour
// - core is a three-stage pipeline, one instruction per stage at once
// - stage one fetches/decodes, two makes address/operand, three executes
// - code fetch path is 16 bits, two code bytes each state
// - data path is 8 bits, one byte per state
// - code and data share one linear 16MB address space
// - lowest 32 data bytes are also four register banks inside core; core keeps its banks off the data bus, so addresses 0 to 31 go out to memory
// - a further 32 register bytes sit in the register file
// - registers 0 to 15 are byte, word or dword operands
// - registers 16 to 31 are word or dword only
// - registers 56 to 63 are dword only
// - sixteen byte, sixteen word and ten dword registers decode
// - data ops are 8 and 16 bit, some 32 bit; bit and flow ops
// - register mode reads operand from the named register
// - immediate mode takes operand from instruction bytes
// - direct mode takes operand address from instruction bytes
// - indirect mode reads operand address from named register
// - displacement mode address is register plus signed offset
// - relative mode target is next instruction address plus offset
// - bit mode instruction carries the bit address
// - 62 maskable sources plus non-maskable and break interrupts
// - each maskable source has its own enable and priority
// - non-maskable always enabled, second only to break
// - four maskable priority levels
// - one machine cycle per state, a state is two clocks
package orc_pkg;
    localparam int ADDR_W     = 24;
    localparam int NUM_IRQ    = 62;
    localparam int PRIO_W     = 2;
    localparam int STATE_CLKS = 2;
    localparam int RF_BYTES   = 64;
    localparam logic [5:0] BYTE_MAX  = 6'h0F;
    localparam logic [5:0] WORD_MAX  = 6'h1F;
    localparam logic [5:0] DW_LO     = 6'h38;
    localparam logic [5:0] BANK_MASK = 6'h1F;
    localparam logic [5:0] IRQ_NMI   = 6'h3E;
    localparam logic [5:0] IRQ_BRK   = 6'h3F;
    localparam logic [5:0] BANK_REGS = 6'h08;
    localparam logic [5:0] FILE_OFS  = 6'h18;
    localparam logic [23:0] FETCH_STEP = 24'h000002;
    localparam logic [23:0] ADDR_LAST = 24'hFFFFFF;

    typedef enum logic [1:0] { W_BYTE, W_WORD, W_DWORD, W_BIT } orc_width_t;
    typedef enum logic [2:0] {
        M_REG, M_IMM, M_DIR, M_IND, M_DISP, M_REL, M_BIT
    } orc_mode_t;
    typedef enum logic [1:0] { OP_DATA, OP_BIT, OP_FLOW, OP_NONE } orc_kind_t;

    // decoded instruction carried down the pipe
    typedef struct packed {
        logic         valid;
        orc_kind_t    kind;
        orc_mode_t    mode;
        orc_width_t   width;
        logic [5:0]   rd;
        logic [5:0]   rs;
        logic [23:0]  imm;
        logic [23:0]  next_pc;
    } orc_instr_t;
endpackage : orc_pkg

/* File: rtl/orc_irq_arb.sv */
`timescale 1ns/1ps
module orc_irq_arb (
    input  wire logic                 clk_in,
    input  wire logic                 rst_n_in,
    input  wire logic [61:0]          irq_req_in,
    input  wire logic [61:0]          irq_en_in,
    input  wire logic [123:0]         irq_prio_in,
    input  wire logic                 nmi_in,
    input  wire logic                 brk_in,
    output logic                      take_out,
    output logic [5:0]                id_r_out
);
    logic [5:0] id_nxt;
    logic       hit;
    logic [1:0] best;

    // lowest index wins among equals; break over nmi over all maskable
    always_comb begin
        id_nxt = 6'h00;
        hit    = 1'b0;
        best   = 2'h0;
        for (int i = orc_pkg::NUM_IRQ - 1; i >= 0; i--) begin
            if (irq_req_in[i] && irq_en_in[i] &&
                (!hit || irq_prio_in[2*i +: 2] >= best)) begin
                hit    = 1'b1;
                best   = irq_prio_in[2*i +: 2];
                id_nxt = 6'(i);
            end
        end
        if (nmi_in) begin
            hit    = 1'b1;
            id_nxt = orc_pkg::IRQ_NMI;
        end
        if (brk_in) begin
            hit    = 1'b1;
            id_nxt = orc_pkg::IRQ_BRK;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            take_out <= 1'b0;
            id_r_out <= 6'h00;
        end else begin
            take_out <= hit;
            id_r_out <= id_nxt;
        end
    end

    chk_nmi_over_mask: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) nmi_in && !brk_in |=>
        take_out && id_r_out == orc_pkg::IRQ_NMI)
        else $error("nmi lost to a maskable source");
    chk_brk_top: assert property (@(posedge clk_in)
        disable iff (!rst_n_in) brk_in |=> id_r_out == orc_pkg::IRQ_BRK)
        else $error("break not highest");
endmodule : orc_irq_arb

/* File: bench/orc_mem_model.sv */
`timescale 1ns/1ps
module orc_mem_model (
    input  wire logic        clk_in,
    input  wire logic [23:0] code_addr_in,
    input  wire logic [23:0] data_addr_in,
    input  wire logic        data_rd_in,
    output logic [15:0]      code_out,
    output logic             code_vld_out,
    output logic [7:0]       data_rdata_out
);
    logic [7:0] last_r = 8'hA5;
    logic [7:0] byte_nxt;
    // ------------------------------------------------------------
    // code and data memories
    // ------------------------------------------------------------
    // two code bytes a state, low byte at the even address
    assign code_out     = {code_addr_in[7:0] + 8'h01, code_addr_in[7:0]};
    assign code_vld_out = 1'b1;
    assign byte_nxt = data_addr_in[7:0] ^ data_addr_in[15:8]
                    ^ data_addr_in[23:16];
    // idle bus toggles so a late sample never sees a stale byte
    always_comb begin
        if (data_rd_in) begin
            data_rdata_out = byte_nxt;
        end else begin
            data_rdata_out = ~last_r;
        end
    end
    always_ff @(posedge clk_in) begin
        last_r <= data_rdata_out;
    end
endmodule : orc_mem_model

/* File: bench/cpu_operand_and_register_core_tb_top.sv */
`timescale 1ns/1ps
module cpu_operand_and_register_core_tb_top;
    logic clk_in = 1'b0, rst_n_in = 1'b0, code_vld_in, data_rd_out;
    logic data_wr_out, irq_take_out, state_out, wb_vld_out;
    logic width_err_out, nmi_in = 1'b0, brk_in = 1'b0;
    logic [15:0] code_in, fetch_word_out;
    logic [23:0] code_addr_out, data_addr_out, ea_out, rd_addr, a, e;
    logic [23:0] ea_got, wr_addr;
    logic [7:0]  data_wdata_out, data_rdata_in, wr_data;
    logic [31:0] dw_m [10];
    int n_wr = 0;
    logic [1:0]  bank_sel_in = 2'h0, got;
    logic [61:0] irq_req_in = '0, irq_en_in = '0;
    logic [123:0] irq_prio_in = '0;
    logic [5:0]  irq_id_out, exp_id;
    logic [31:0] result_out, rs = 32'h0F62E620;
    orc_pkg::orc_instr_t dec_in = '0, ins;
    int n_errors = 0, checks_done = 0, cycles = 0, best, ok_cnt[3];
    always #20 clk_in = ~clk_in;
    orc_core i_orc_core (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .code_in(code_in), .code_vld_in(code_vld_in),
        .code_addr_out(code_addr_out), .dec_in(dec_in),
        .data_addr_out(data_addr_out), .data_rd_out(data_rd_out),
        .data_wr_out(data_wr_out), .data_wdata_out(data_wdata_out),
        .data_rdata_in(data_rdata_in), .bank_sel_in(bank_sel_in),
        .irq_req_in(irq_req_in), .irq_en_in(irq_en_in),
        .irq_prio_in(irq_prio_in), .nmi_in(nmi_in), .brk_in(brk_in),
        .irq_take_out(irq_take_out), .irq_id_out(irq_id_out),
        .state_out(state_out), .fetch_word_out(fetch_word_out),
        .result_out(result_out), .ea_out(ea_out),
        .wb_vld_out(wb_vld_out), .width_err_out(width_err_out));
    orc_mem_model i_orc_mem_model (.clk_in(clk_in),
        .code_addr_in(code_addr_out), .data_addr_in(data_addr_out),
        .data_rd_in(data_rd_out), .code_out(code_in),
        .code_vld_out(code_vld_in), .data_rdata_out(data_rdata_in));
    always @(posedge clk_in) begin
        if (data_rd_out === 1'b1) rd_addr <= data_addr_out;
        if (data_wr_out === 1'b1) begin
            wr_addr <= data_addr_out;
            wr_data <= data_wdata_out;
            n_wr <= n_wr + 1;
        end
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            close_out();
        end
    end
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs
    task automatic chk(input bit ok, input string msg);
        checks_done = checks_done + 1;
        if (!ok) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : chk
    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // ------------------------------------------------------------
    // one instruction through the pipe, taken on a state edge
    // ------------------------------------------------------------
    task automatic run(input orc_pkg::orc_instr_t i);
        int k;
        for (k = 0; k < 4 && state_out !== 1'b1; k++) @(posedge clk_in) #1;
        dec_in = i;
        @(posedge clk_in) #1;
        dec_in = '0;
        repeat (2) @(posedge clk_in) #1;
        ea_got = ea_out;
        repeat (2) @(posedge clk_in) #1;
        got = {width_err_out === 1'b1, wb_vld_out === 1'b1};
        chk((got != 2'b00) == (i.kind == orc_pkg::OP_DATA),
            "writeback");
    endtask : run
    function automatic logic [5:0] dw_reg(int d);
        return (d < 8) ? 6'(4 * d) : 6'(24 + 4 * d);
    endfunction : dw_reg
    function automatic bit legal(int r, int w);
        if (w == 0) return r <= 15;
        if (w == 1) return r % 2 == 0 && r <= 30;
        return r % 4 == 0 && (r <= 31 || r >= 56);
    endfunction : legal
    initial begin
        repeat (20) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        bank_sel_in = 2'(xs());
        repeat (4) @(posedge clk_in) #1;
        for (int k = 0; k < 4 && state_out !== 1'b1; k++) @(posedge clk_in) #1;
        a = code_addr_out;
        repeat (2) @(posedge clk_in) #1;
        chk(code_addr_out === a + 24'h2, "fetch step");
        chk(fetch_word_out === {a[7:0] + 8'h01, a[7:0]}, "fetch word");
        // byte, word and dword width of every register number: accept or refuse
        for (int w = 0; w < 3; w++) begin
            ok_cnt[w] = 0;
            for (int r = 0; r < 64; r++) begin
                ins = '0;
                ins.valid = 1'b1;
                ins.kind = orc_pkg::OP_DATA;
                ins.mode = orc_pkg::M_REG;
                ins.width = orc_pkg::orc_width_t'(w);
                ins.rd = 6'(r);
                ins.rs = 6'(r);
                run(ins);
                chk(got[1] === !legal(r, w), "width check");
                if (got == 2'b01) ok_cnt[w]++;
            end
        end
        chk(ok_cnt[0] == 16 && ok_cnt[1] == 16, "reg count");
        chk(ok_cnt[2] == 10, "dword count");
        for (int t = 0; t < 12; t++) begin
            ins = '0;
            ins.valid = 1'b1;
            ins.kind = orc_pkg::OP_DATA;
            ins.mode = orc_pkg::M_DIR;
            ins.imm = (t == 0) ? orc_pkg::ADDR_LAST : 24'(xs());
            run(ins);
            a = ins.imm;
            chk(ea_got === a && rd_addr === a, "direct ea");
            chk(result_out[7:0] === (a[7:0] ^ a[15:8] ^ a[23:16]),
                "direct data");
            ins.mode = orc_pkg::M_IMM;
            ins.width = orc_pkg::W_WORD;
            run(ins);
            chk(result_out[15:0] === a[15:0], "immediate");
            ins.kind = orc_pkg::OP_FLOW;
            ins.mode = orc_pkg::M_REL;
            ins.next_pc = 24'(xs());
            run(ins);
            chk(ea_got === ins.next_pc + {{16{a[7]}}, a[7:0]}, "relative");
        end
        // ten dword registers: write all, disturb another bank, read back
        for (int d = 0; d < 10; d++) begin
            ins = '0;
            ins.valid = 1'b1;
            ins.kind = orc_pkg::OP_DATA;
            ins.mode = orc_pkg::M_IMM;
            ins.width = orc_pkg::W_DWORD;
            ins.rd = dw_reg(d);
            ins.imm = 24'(xs());
            dw_m[d] = {8'h00, ins.imm};
            run(ins);
        end
        bank_sel_in = ~bank_sel_in;
        ins.rd = 6'h00;
        ins.imm = ~dw_m[0][23:0];
        run(ins);
        bank_sel_in = ~bank_sel_in;
        ok_cnt[2] = 0;
        for (int d = 0; d < 10; d++) begin
            ins.rd = dw_reg(d);
            ins.rs = ins.rd;
            ins.mode = orc_pkg::M_REG;
            run(ins);
            chk(result_out === dw_m[d], "reg read");
            if (result_out === dw_m[d]) ok_cnt[2]++;
        end
        chk(ok_cnt[2] == 10, "distinct dwords");
        // memory modes through a bit op: read, flip one bit, write back
        for (int d = 0; d < 30; d++) begin
            ins = '0;
            ins.valid = 1'b1;
            ins.kind = orc_pkg::OP_BIT;
            ins.width = orc_pkg::W_DWORD;
            ins.rs = dw_reg(d % 10);
            ins.imm = 24'(xs());
            e = dw_m[d % 10][23:0];
            if (d >= 20) begin
                ins.mode = orc_pkg::M_BIT;
                e = ins.imm;
            end else if (d >= 10) begin
                ins.mode = orc_pkg::M_DISP;
                e = e + {{8{ins.imm[15]}}, ins.imm[15:0]};
            end else begin
                ins.mode = orc_pkg::M_IND;
            end
            best = n_wr;
            run(ins);
            chk(ea_got === e && rd_addr === e, "memory ea");
            chk(n_wr == best + 1 && wr_addr === e, "bit write");
            chk($countones(wr_data ^ (e[7:0] ^ e[15:8] ^ e[23:16])) == 1,
                "one bit");
        end
        for (int t = 0; t < 40; t++) begin
            irq_req_in = 62'({xs(), xs()});
            irq_en_in = (t % 8 == 4) ? '0 : 62'({xs(), xs()});
            irq_prio_in = 124'({xs(), xs(), xs(), xs()});
            brk_in = (t % 4 == 3);
            nmi_in = (t % 4 >= 2);
            best = -1;
            exp_id = 6'h00;
            for (int i = 0; i < 62; i++) begin
                if (irq_req_in[i] && irq_en_in[i]
                    && int'(irq_prio_in[2*i +: 2]) > best) begin
                    best = int'(irq_prio_in[2*i +: 2]);
                    exp_id = 6'(i);
                end
            end
            if (nmi_in) exp_id = orc_pkg::IRQ_NMI;
            if (brk_in) exp_id = orc_pkg::IRQ_BRK;
            @(posedge clk_in) #1;
            chk(irq_take_out === (best >= 0 || nmi_in || brk_in), "take");
            if (irq_take_out === 1'b1) begin
                chk(irq_id_out === exp_id, "irq id");
            end
        end
        close_out();
    end
endmodule : cpu_operand_and_register_core_tb_top
